// ==== design/imd_datapath.sv ====
// What this block does
// - Rate field picks ratio 1, 2, 4, 8.
// - Ratio built from chained half-band stages.
// - Two identical channels, I and Q.
// - Single mode: select bit picks I or Q.
// - Divide field: off, /2, /4, /8 carrier.
// - Single mode multiplies by real cosine.
// - Dual mode complex mix, select real/imag.
// - Complex carrier is positive frequency only.
// - Divide code zero bypasses the mixer.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module imd_datapath #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire imd_pkg::imd_iq_t in_sample,
	output logic in_ready,
	output logic signed [W-1:0] dac_data
);
	import imd_pkg::*;

	if (W != IMD_W) begin : g_chk
		$error("W must equal the sample struct width");
	end

	// Register slave: write address and data are latched independently.
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [11:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic arready_reg, arready_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic [2:0] phase_reg, phase_next;
	imd_cfg_t cfg;

	assign cfg = imd_cfg_t'(ctrl_reg[5:0]);

	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next = w_have_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		ctrl_next = ctrl_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		arready_next = 1'b0;
		if (s_axi_awvalid && !aw_have_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_reg) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			if (aw_addr_reg == IMD_CTRL_OFS) begin
				bresp_next = 2'b00;
				if (w_strb_reg[0]) begin
					ctrl_next[7:0] = w_data_reg[7:0] & IMD_CTRL_MASK[7:0];
				end
			end else if (aw_addr_reg == IMD_STAT_OFS) begin
				bresp_next = 2'b00;
			end else begin
				bresp_next = 2'b10;
			end
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_reg && !arready_reg) begin
			arready_next = 1'b1;
			rvalid_next = 1'b1;
			rresp_next = 2'b00;
			if (s_axi_araddr == IMD_CTRL_OFS) begin
				rdata_next = ctrl_reg;
			end else if (s_axi_araddr == IMD_STAT_OFS) begin
				rdata_next = {29'h00000000, phase_reg};
			end else begin
				rdata_next = 32'h00000000;
				rresp_next = 2'b10;
			end
		end
		// The ready lines are registered copies of the free state so that they leave from flops.
		awready_next = !aw_have_next;
		wready_next = !w_have_next;
	end

	// Interpolation phase state.
	logic [2:0] slot_reg, slot_next;
	logic in_ready_reg, in_ready_next;
	imd_iq_t held_reg, held_next;
	imd_iq_t stage_reg [0:3];
	imd_iq_t stage_next [0:3];
	imd_iq_t prev_reg [0:2];
	imd_iq_t prev_next [0:2];
	logic signed [W-1:0] out_reg, out_next;
	logic [2:0] last_slot;
	imd_iq_t filt;
	logic signed [W-1:0] cosv, sinv, mix_re, mix_im;
	logic signed [W-1:0] cos_tab [0:7];
	logic signed [W-1:0] sin_tab [0:7];

	always_comb begin
		case (cfg.upsample_ratio_sel)
			IMD_RATE_X1: last_slot = 3'h0;
			IMD_RATE_X2: last_slot = 3'h1;
			IMD_RATE_X4: last_slot = 3'h3;
			default: last_slot = 3'h7;
		endcase
	end

	// One input sample per ratio of output clocks; at ratio 8 each stage doubles the rate.
	always_comb begin
		slot_next = (slot_reg >= last_slot) ? 3'h0 : slot_reg + 3'h1;
		in_ready_next = (slot_next == 3'h0);
		held_next = (in_ready_reg) ? in_sample : held_reg;
		phase_next = phase_reg + 3'h1;
		stage_next[0] = held_next;
	end

	// Each half-band stage: even outputs copy the sample, odd ones average
	// the last two, so I and Q see the same real response.
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_hb
			logic [2:0] step;
			assign step = 3'(1 << (2 - g));
			always_comb begin
				stage_next[g+1] = stage_reg[g+1];
				prev_next[g] = prev_reg[g];
				if ((slot_reg & (step - 3'h1)) == 3'h0) begin
					if ((slot_reg & step) == 3'h0) begin
						stage_next[g+1] = stage_reg[g];
						prev_next[g] = stage_reg[g];
					end else begin
						stage_next[g+1].i = W'((32'(signed'(stage_reg[g].i)) + 32'(signed'(prev_reg[g].i))) >>> 1);
						stage_next[g+1].q = W'((32'(signed'(stage_reg[g].q)) + 32'(signed'(prev_reg[g].q))) >>> 1);
					end
				end
			end
		end
	endgenerate

	always_comb begin
		case (cfg.upsample_ratio_sel)
			IMD_RATE_X1: filt = stage_reg[0];
			IMD_RATE_X2: filt = stage_reg[1];
			IMD_RATE_X4: filt = stage_reg[2];
			default: filt = stage_reg[3];
		endcase
	end

	// Cosine and sine tables over eight phases, scaled to full range.
	localparam logic signed [15:0] CK = 16'h7FFF;
	localparam logic signed [15:0] CH = 16'h5A82;

	always_comb begin
		cos_tab = '{CK, CH, 16'h0000, -CH, -CK, -CH, 16'h0000, CH};
		sin_tab = '{16'h0000, CH, CK, CH, 16'h0000, -CH, -CK, -CH};
		case (cfg.carrier_div_sel)
			IMD_DIV_2: begin
				cosv = cos_tab[{phase_reg[0], 2'b00}];
				sinv = sin_tab[{phase_reg[0], 2'b00}];
			end
			IMD_DIV_4: begin
				cosv = cos_tab[{phase_reg[1:0], 1'b0}];
				sinv = sin_tab[{phase_reg[1:0], 1'b0}];
			end
			default: begin
				cosv = cos_tab[phase_reg];
				sinv = sin_tab[phase_reg];
			end
		endcase
	end

	function automatic logic signed [W-1:0] qmul(input logic signed [W-1:0] a, input logic signed [W-1:0] b);
		logic signed [2*W-1:0] p;
		p = a * b;
		return p[2*W-2:W-1];
	endfunction

	// Complex product with exp(+j w n): sine lags cosine, positive frequency.
	always_comb begin
		mix_re = W'(32'(signed'(qmul(filt.i, cosv))) - 32'(signed'(qmul(filt.q, sinv))));
		mix_im = W'(32'(signed'(qmul(filt.i, sinv))) + 32'(signed'(qmul(filt.q, cosv))));
		if (cfg.carrier_div_sel == IMD_DIV_OFF) begin
			out_next = (cfg.chan_sel && cfg.complex_mix_en) ? filt.q :
				(cfg.chan_sel ? filt.q : filt.i);
		end else if (cfg.complex_mix_en) begin
			out_next = cfg.chan_sel ? mix_im : mix_re;
		end else begin
			out_next = cfg.chan_sel ? qmul(filt.q, cosv) : qmul(filt.i, cosv);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'b00;
			rdata_reg <= 32'h00000000;
			arready_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			ctrl_reg <= IMD_CTRL_RST;
			phase_reg <= 3'h0;
			slot_reg <= 3'h0;
			in_ready_reg <= 1'b0;
			held_reg <= '0;
			out_reg <= '0;
			for (int k = 0; k < 4; k++) begin
				stage_reg[k] <= '0;
			end
			for (int k = 0; k < 3; k++) begin
				prev_reg[k] <= '0;
			end
		end else begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg <= w_have_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			arready_reg <= arready_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			ctrl_reg <= ctrl_next;
			phase_reg <= phase_next;
			slot_reg <= slot_next;
			in_ready_reg <= in_ready_next;
			held_reg <= held_next;
			out_reg <= out_next;
			stage_reg <= stage_next;
			prev_reg <= prev_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign in_ready = in_ready_reg;
	assign dac_data = out_reg;

	// Checks.
	property p_phase_free;
		@(posedge aclk) disable iff (!aresetn) phase_reg == 3'h7 |=> phase_reg == 3'h0;
	endproperty
	a_phase_free: assert property (p_phase_free) else $error("carrier phase not free running");

	property p_x1_ready;
		@(posedge aclk) disable iff (!aresetn) cfg.upsample_ratio_sel == IMD_RATE_X1 [*3] |-> in_ready_reg;
	endproperty
	a_x1_ready: assert property (p_x1_ready) else $error("ratio one must take every cycle");

	property p_x2_spacing;
		@(posedge aclk) disable iff (!aresetn)
			(cfg.upsample_ratio_sel == IMD_RATE_X2) throughout (in_ready_reg ##1 1'b1) |-> !in_ready_reg;
	endproperty
	a_x2_spacing: assert property (p_x2_spacing) else $error("ratio two takes too often");

	property p_bypass;
		@(posedge aclk) disable iff (!aresetn)
			cfg.carrier_div_sel == IMD_DIV_OFF && !cfg.chan_sel && $stable(ctrl_reg) |=> out_reg == $past(filt.i);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass output differs from I");

	property p_single_q;
		@(posedge aclk) disable iff (!aresetn)
			cfg.carrier_div_sel == IMD_DIV_OFF && cfg.chan_sel |=> out_reg == $past(filt.q);
	endproperty
	a_single_q: assert property (p_single_q) else $error("select one must give Q");

	property p_write_resp;
		@(posedge aclk) disable iff (!aresetn) aw_have_reg && w_have_reg && !bvalid_reg |=> bvalid_reg;
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response missing");

	c_x8: cover property (@(posedge aclk) cfg.upsample_ratio_sel == IMD_RATE_X8 && in_ready_reg);
	c_cplx: cover property (@(posedge aclk) cfg.complex_mix_en && cfg.carrier_div_sel == IMD_DIV_8);
	c_real: cover property (@(posedge aclk) !cfg.complex_mix_en && cfg.carrier_div_sel == IMD_DIV_4);
endmodule // imd_datapath

// ==== design/imd_pkg.sv ====
package imd_pkg;
	// Register byte offsets.
	localparam logic [11:0] IMD_CTRL_OFS = 12'h000;
	localparam logic [11:0] IMD_STAT_OFS = 12'h004;
	// Control field positions.
	localparam int IMD_RATE_LSB = 0;
	localparam int IMD_DIV_LSB = 2;
	localparam int IMD_CHAN_BIT = 4;
	localparam int IMD_CPLX_BIT = 5;
	localparam logic [31:0] IMD_CTRL_RST = 32'h00000000;
	localparam logic [31:0] IMD_CTRL_MASK = 32'h0000003F;
	localparam int IMD_W = 16;

	typedef enum logic [1:0] {
		IMD_RATE_X1 = 2'b00,
		IMD_RATE_X2 = 2'b01,
		IMD_RATE_X4 = 2'b10,
		IMD_RATE_X8 = 2'b11
	} imd_rate_t;

	typedef enum logic [1:0] {
		IMD_DIV_OFF = 2'b00,
		IMD_DIV_2 = 2'b01,
		IMD_DIV_4 = 2'b10,
		IMD_DIV_8 = 2'b11
	} imd_div_t;

	typedef struct packed {
		logic complex_mix_en;
		logic chan_sel;
		imd_div_t carrier_div_sel;
		imd_rate_t upsample_ratio_sel;
	} imd_cfg_t;

	typedef struct packed {
		logic signed [IMD_W-1:0] i;
		logic signed [IMD_W-1:0] q;
	} imd_iq_t;

	typedef enum logic [1:0] {
		IMD_WR_IDLE = 2'b00,
		IMD_WR_RESP = 2'b01
	} imd_wr_state_t;
endpackage

// ==== test/imd_src_model.sv ====
`timescale 1ns/1ps
module imd_src_model (
	input wire logic in_ready,
	input wire logic signed [15:0] i_val,
	input wire logic signed [15:0] q_val,
	output imd_pkg::imd_iq_t in_sample
);
	import imd_pkg::*;
	// Outside a capture cycle the lines show the inverted pattern, so a stray capture is visible.
	assign in_sample = in_ready ? {i_val, q_val} : {~i_val, ~q_val};
endmodule // imd_src_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import imd_pkg::*;
	logic aclk;
	logic aresetn;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, in_ready;
	logic [1:0] bresp, rresp, r;
	logic signed [15:0] i_val, q_val, dac_data, mx;
	logic signed [15:0] ra[8], rb[8], rc[8];
	imd_iq_t in_sample;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	imd_datapath #(.W(IMD_W)) u_imd_datapath (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.in_sample(in_sample), .in_ready(in_ready), .dac_data(dac_data));
	imd_src_model u_imd_src_model (.in_ready(in_ready), .i_val(i_val), .q_val(q_val), .in_sample(in_sample));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;
	task automatic wrap_up;
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp, input int tol);
		int diff;
		diff = $signed(seen) - $signed(exp);
		compares++;
		if ($isunknown(seen) || diff > tol || diff < -tol) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, $signed(exp), $signed(seen));
		end
	endtask
	task automatic bus_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		int k;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (k == 100) begin
			check("write timeout", 32'h1, 32'h0, 0);
			wrap_up;
		end
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic bus_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (k == 100) begin
			check("read timeout", 32'h1, 32'h0, 0);
			wrap_up;
		end
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic cfg(input logic [5:0] c, input logic signed [15:0] iv, input logic signed [15:0] qv);
		bus_wr(IMD_CTRL_OFS, {26'h0, c}, r);
		i_val <= iv;
		q_val <= qv;
		repeat (48) @(posedge aclk);
	endtask
	// Each output sample lands in the slot of its absolute cycle modulo eight.
	task automatic grab;
		repeat (8) begin
			@(posedge aclk);
			ra[cyc % 8] = dac_data;
		end
	endtask
	task automatic flat(input logic [5:0] c, input logic signed [15:0] iv, qv, exp, input string what);
		cfg(c, iv, qv);
		grab;
		for (int k = 0; k < 8; k++) check(what, ra[k], exp, 0);
	endtask
	task automatic t_regs;
		bus_rd(IMD_CTRL_OFS, d, r);
		check("ctrl reset", d, IMD_CTRL_RST, 0);
		check("ctrl rresp", r, 2'b00, 0);
		bus_wr(IMD_CTRL_OFS, 32'hFFFFFFFF, r);
		bus_rd(IMD_CTRL_OFS, d, r);
		check("ctrl mask", d, IMD_CTRL_MASK, 0);
		bus_rd(12'h008, d, r);
		check("unmapped rresp", r, 2'b10, 0);
		check("unmapped rdata", d, 32'h0, 0);
		bus_wr(12'h008, 32'h0000000F, r);
		check("unmapped bresp", r, 2'b10, 0);
		bus_rd(IMD_STAT_OFS, d, r);
		check("stat upper", d >> 3, 32'h0, 0);
	endtask
	task automatic t_rate;
		for (int k = 0; k < 4; k++) begin
			cfg({4'h0, 2'(k)}, 16'sh0100, 16'sh0100);
			n = 0;
			repeat (64) begin
				@(posedge aclk);
				n += int'(in_ready);
			end
			check("ready count", n, 64 >> k, 0);
		end
	endtask
	task automatic t_real;
		for (int m = 1; m < 4; m++) begin
			cfg({2'b00, 2'(m), IMD_RATE_X8}, 16'sh4000, 16'sh0000);
			grab;
			mx = 16'sh0000;
			for (int k = 0; k < 8; k++) begin
				check("half period", ra[(k + (1 << m) / 2) % 8], -ra[k], 2);
				check("period", ra[(k + (1 << m)) % 8], ra[k], 0);
				if (ra[k] > mx) mx = ra[k];
			end
			check("peak", mx, 16'sh4000, 4);
		end
		cfg({2'b01, IMD_DIV_4, IMD_RATE_X8}, 16'sh0000, 16'sh4000);
		grab;
		rb = ra;
		cfg({2'b00, IMD_DIV_4, IMD_RATE_X8}, 16'sh4000, 16'sh0000);
		grab;
		for (int k = 0; k < 8; k++) check("single q carrier", rb[k], ra[k], 0);
	endtask
	task automatic t_cplx;
		for (int m = 2; m < 4; m++) begin
			cfg({2'b10, 2'(m), IMD_RATE_X8}, 16'sh0000, 16'sh4000);
			grab;
			rb = ra;
			cfg({2'b11, 2'(m), IMD_RATE_X8}, 16'sh4000, 16'sh0000);
			grab;
			rc = ra;
			cfg({2'b10, 2'(m), IMD_RATE_X8}, 16'sh4000, 16'sh0000);
			grab;
			for (int k = 0; k < 8; k++) begin
				check("quadrature lead", rb[k], ra[(k + (1 << m) / 4) % 8], 2);
				check("imag part", rc[k], -rb[k], 2);
			end
		end
	endtask
	// A reset in mid-run must clear the stream outputs and the control word.
	task automatic t_reset;
		bus_wr(IMD_CTRL_OFS, 32'h0000003C, r);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		check("reset dac", dac_data, 32'h0, 0);
		check("reset ready", in_ready, 32'h0, 0);
		aresetn <= 1'b1;
		bus_rd(IMD_CTRL_OFS, d, r);
		check("ctrl after reset", d, IMD_CTRL_RST, 0);
	endtask
	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		i_val = 16'sh0000;
		q_val = 16'sh0000;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_rate;
		flat({2'b00, IMD_DIV_OFF, IMD_RATE_X8}, 16'sh03E8, 16'shF830, 16'sh03E8, "single i");
		flat({2'b01, IMD_DIV_OFF, IMD_RATE_X4}, 16'sh03E8, 16'shF830, 16'shF830, "single q");
		flat({2'b10, IMD_DIV_OFF, IMD_RATE_X2}, 16'sh03E8, 16'shF830, 16'sh03E8, "dual real");
		flat({2'b00, IMD_DIV_4, IMD_RATE_X8}, 16'sh0000, 16'sh4000, 16'sh0000, "single ignores q");
		flat({2'b11, IMD_DIV_OFF, IMD_RATE_X1}, 16'sh03E8, 16'shF830, 16'shF830, "dual imag");
		t_real;
		t_cplx;
		t_reset;
		wrap_up;
	end
endmodule // testbench
